// ---- shared/rsl_defs.svh ----
`ifndef RSL_DEFS_SVH
`define RSL_DEFS_SVH

// Timing
`define RSL_CLK_MHZ 40
`define RSL_HOLD_NS 100
`define RSL_HOLD_CYC ((`RSL_HOLD_NS * `RSL_CLK_MHZ + 999) / 1000)

// Register indices; byte offset is index times four
`define RSL_NREG 22
`define RSL_IDX_IND0 0
`define RSL_IDX_MP0 1
`define RSL_IDX_IND1 2
`define RSL_IDX_MEMORY_POINTER_1_LOW 3
`define RSL_IDX_MEMORY_POINTER_1_HIGH 4
`define RSL_IDX_ACC 5
`define RSL_IDX_PCL 6
`define RSL_IDX_TABLE_POINTER 7
`define RSL_IDX_TABLE_HIGH_DATA 8
`define RSL_IDX_TABLE_HIGH_POINTER 9
`define RSL_IDX_STAT 10
`define RSL_IDX_PBP 11
`define RSL_IDX_IND2 12
`define RSL_IDX_MEMORY_POINTER_2_LOW 13
`define RSL_IDX_MEMORY_POINTER_2_HIGH 14
`define RSL_IDX_RSTF 15
`define RSL_IDX_INTERRUPT_CONTROL_0 16
`define RSL_IDX_INTERRUPT_CONTROL_1 17
`define RSL_IDX_INTERRUPT_CONTROL_2 18
`define RSL_IDX_INTERRUPT_CONTROL_3 19
`define RSL_IDX_PA 20
`define RSL_IDX_PAC 21

// Field positions
`define RSL_STAT_TO_BIT 5
`define RSL_STAT_PDF_BIT 4
`define RSL_RSTF_BO_BIT 2

// Reset values and implemented-bit masks
`define RSL_ZERO_RST 8'h00
`define RSL_ONES_RST 8'hff
`define RSL_UNDEF_POR 8'h00
`define RSL_RSTF_POR 8'h00
`define RSL_MASK_FULL 8'hff
`define RSL_MASK_TABLE_HIGH_POINTER 8'h3f
`define RSL_MASK_PBP 8'h01
`define RSL_MASK_INTERRUPT_CONTROL_0 8'h7f
`define RSL_MASK_RSTF 8'h0f

`endif

// ---- shared/rsl_pkg.sv ----
`include "rsl_defs.svh"

package rsl_pkg;

   typedef enum logic [1:0] {
      RSL_FAST = 2'b00,
      RSL_SLOW = 2'b01,
      RSL_IDLE = 2'b10,
      RSL_SLEEP = 2'b11
   } rsl_mode_t;

   typedef enum logic [1:0] {
      RSL_C_POR = 2'b00,
      RSL_C_PIN = 2'b01,
      RSL_C_BO = 2'b10,
      RSL_C_WDT = 2'b11
   } rsl_cause_t;

   typedef enum logic [1:0] {
      RSL_SQ_IDLE = 2'b00,
      RSL_SQ_APPLY = 2'b01,
      RSL_SQ_HOLD = 2'b10
   } rsl_seq_t;

   typedef enum logic [2:0] {
      RSL_CLS_ZERO = 3'b000,
      RSL_CLS_ONES = 3'b001,
      RSL_CLS_PCL = 3'b010,
      RSL_CLS_KEEP = 3'b011,
      RSL_CLS_STAT = 3'b100,
      RSL_CLS_RSTF = 3'b101
   } rsl_cls_t;

   typedef struct packed {
      logic por;
      logic pin;
      logic brownout;
   } rsl_req_t;

   typedef struct packed {
      logic pc_clear;
      logic sp_top;
      logic sp_clear;
      logic int_disable;
      logic wdt_tb_clear;
      logic timers_off;
      logic ports_input;
   } rsl_ctl_t;

   typedef struct packed {
      logic watchdog_expiry_flag;
      logic powerdown_flag;
      logic brownout_flag;
      logic [7:0] port_a_data;
      logic [7:0] port_a_direction;
   } rsl_view_t;

   typedef struct packed {
      logic rd_load;
      logic wr_en;
      logic hit;
      logic [4:0] idx;
   } rsl_acc_t;

   typedef struct packed {
      rsl_seq_t seq;
      rsl_cause_t cause;
      logic lowpwr;
      logic [3:0] cnt;
      logic core_rst_b;
      rsl_ctl_t ctl;
      logic [7:0] rdata;
      logic [`RSL_NREG-1:0][7:0] regs;
   } rsl_core_st_t;

   function automatic rsl_cls_t rsl_reg_cls(input int idx);
      case (idx)
         `RSL_IDX_ACC, `RSL_IDX_TABLE_POINTER, `RSL_IDX_TABLE_HIGH_DATA,
         `RSL_IDX_TABLE_HIGH_POINTER: rsl_reg_cls = RSL_CLS_KEEP;
         `RSL_IDX_PCL: rsl_reg_cls = RSL_CLS_PCL;
         `RSL_IDX_STAT: rsl_reg_cls = RSL_CLS_STAT;
         `RSL_IDX_RSTF: rsl_reg_cls = RSL_CLS_RSTF;
         `RSL_IDX_PA, `RSL_IDX_PAC: rsl_reg_cls = RSL_CLS_ONES;
         default: rsl_reg_cls = RSL_CLS_ZERO;
      endcase
   endfunction : rsl_reg_cls

   function automatic logic [7:0] rsl_reg_mask(input int idx);
      case (idx)
         `RSL_IDX_TABLE_HIGH_POINTER: rsl_reg_mask = `RSL_MASK_TABLE_HIGH_POINTER;
         `RSL_IDX_PBP: rsl_reg_mask = `RSL_MASK_PBP;
         `RSL_IDX_INTERRUPT_CONTROL_0: rsl_reg_mask = `RSL_MASK_INTERRUPT_CONTROL_0;
         `RSL_IDX_RSTF: rsl_reg_mask = `RSL_MASK_RSTF;
         default: rsl_reg_mask = `RSL_MASK_FULL;
      endcase
   endfunction : rsl_reg_mask

endpackage : rsl_pkg

// ---- src/rsl_sync.sv ----
`timescale 1ns/1ps

module rsl_sync #(
   parameter int W = 3
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } rsl_sync_st_t;

   rsl_sync_st_t r;
   rsl_sync_st_t next_r;

   // First stage feeds only the second stage
   always_comb begin
      next_r.ff1 = d;
      next_r.ff2 = r.ff1;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.ff2;
endmodule : rsl_sync

// ---- src/rsl_avmm.sv ----
`timescale 1ns/1ps
`include "rsl_defs.svh"

module rsl_avmm (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [6:0] avs_address,
   input wire logic busy,
   output logic avs_waitrequest,
   output rsl_pkg::rsl_acc_t acc
);
   import rsl_pkg::*;

   typedef struct packed {
      logic ack;
   } rsl_avmm_st_t;

   rsl_avmm_st_t r;
   rsl_avmm_st_t next_r;
   logic start;

   // One wait cycle; held off while a reset sequence runs
   always_comb begin
      start = (avs_read | avs_write) & ~r.ack & ~busy;
      next_r.ack = start;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign avs_waitrequest = ~r.ack;
   assign acc.rd_load = avs_read & start;
   assign acc.wr_en = avs_write & r.ack;
   assign acc.idx = avs_address[6:2];
   assign acc.hit = (avs_address[1:0] == 2'b00)
      && (avs_address[6:2] < 5'(`RSL_NREG));
endmodule : rsl_avmm

// ---- src/rsl_core.sv ----
`timescale 1ns/1ps
`include "rsl_defs.svh"

// What this block does
// - Status holds watchdog-expiry and powerdown flags
// - Power-on reset clears both flags
// - Pin or brownout reset running keeps flags
// - Running watchdog reset sets expiry, keeps powerdown
// - Low-power watchdog reset sets both flags
// - Power-on reset loads program counter zero
// - Power-on reset disables all interrupts
// - Power-on clears watchdog, time bases; restart
// - Power-on reset switches timers off
// - Power-on reset makes all pins inputs
// - Power-on reset sets stack pointer top
// - Memory pointers zeroed except low-power watchdog reset
// - Accumulator, table registers kept except power-on
// - Program counter low cleared by every reset
// - Status bits 5:4 per reset cause
// - Interrupt controls zeroed except low-power watchdog
// - Port A ones except low-power watchdog
// - Reset-flag bits cleared at power-on, else kept except the brownout bit
// - Brownout flag set on brownout, software clears
// - Low-power watchdog clears counter and stack only

module rsl_core (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire rsl_pkg::rsl_req_t rst_req,
   input wire logic wdt_expiry,
   input wire rsl_pkg::rsl_mode_t mode,
   input wire logic sleep_entry,
   input wire logic flag_clear,
   input wire logic [6:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic core_rst_b,
   output rsl_pkg::rsl_ctl_t ctl,
   output rsl_pkg::rsl_view_t view
);
   import rsl_pkg::*;

   localparam logic [3:0] HOLD_LAST = 4'(`RSL_HOLD_CYC - 1);

   rsl_core_st_t r;
   rsl_core_st_t next_r;
   rsl_req_t req_s;
   rsl_acc_t acc;
   logic wdt_lp;
   logic any_lvl;

   rsl_sync #(
      .W(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d(rst_req),
      .q(req_s)
   );

   rsl_avmm u_avmm (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_address(avs_address),
      .busy(r.seq != RSL_SQ_IDLE),
      .avs_waitrequest(avs_waitrequest),
      .acc(acc)
   );

   assign wdt_lp = (r.cause == RSL_C_WDT) && r.lowpwr;
   assign any_lvl = req_s.por | req_s.pin | req_s.brownout;

   always_comb begin
      next_r = r;
      next_r.ctl = '0;
      // Bus write first so that a reset apply overrides it
      if (acc.wr_en && acc.hit) begin
         if (int'(acc.idx) == `RSL_IDX_STAT) begin
            // Flag bits are hardware-owned
            next_r.regs[acc.idx] = (avs_writedata[7:0] & 8'hcf)
               | (r.regs[acc.idx] & 8'h30);
         end else begin
            next_r.regs[acc.idx] = avs_writedata[7:0]
               & rsl_reg_mask(int'(acc.idx));
         end
      end
      if (acc.rd_load) begin
         next_r.rdata = acc.hit ? r.regs[acc.idx] : 8'h00;
      end
      unique case (r.seq)
         RSL_SQ_IDLE: begin
            if (flag_clear) begin
               next_r.regs[`RSL_IDX_STAT][`RSL_STAT_TO_BIT] = 1'b0;
               next_r.regs[`RSL_IDX_STAT][`RSL_STAT_PDF_BIT] = 1'b0;
            end else if (sleep_entry) begin
               next_r.regs[`RSL_IDX_STAT][`RSL_STAT_TO_BIT] = 1'b0;
               next_r.regs[`RSL_IDX_STAT][`RSL_STAT_PDF_BIT] = 1'b1;
            end
            // Priority: power-on, brownout, pin, watchdog
            if (any_lvl || wdt_expiry) begin
               next_r.seq = RSL_SQ_APPLY;
               next_r.core_rst_b = 1'b0;
               next_r.lowpwr = (mode == RSL_IDLE)
                  || (mode == RSL_SLEEP);
               if (req_s.por) begin
                  next_r.cause = RSL_C_POR;
               end else if (req_s.brownout) begin
                  next_r.cause = RSL_C_BO;
               end else if (req_s.pin) begin
                  next_r.cause = RSL_C_PIN;
               end else begin
                  next_r.cause = RSL_C_WDT;
               end
            end
         end
         RSL_SQ_APPLY: begin
            for (int i = 0; i < `RSL_NREG; i++) begin
               unique case (rsl_reg_cls(i))
                  RSL_CLS_ZERO: begin
                     if (!wdt_lp) begin
                        next_r.regs[i] = `RSL_ZERO_RST;
                     end
                  end
                  RSL_CLS_ONES: begin
                     if (!wdt_lp) begin
                        next_r.regs[i] = `RSL_ONES_RST;
                     end
                  end
                  RSL_CLS_PCL: begin
                     next_r.regs[i] = `RSL_ZERO_RST;
                  end
                  RSL_CLS_KEEP: begin
                     if (r.cause == RSL_C_POR) begin
                        next_r.regs[i] = `RSL_UNDEF_POR
                           & rsl_reg_mask(i);
                     end
                  end
                  RSL_CLS_RSTF: begin
                     if (r.cause == RSL_C_POR) begin
                        next_r.regs[i] = `RSL_RSTF_POR;
                     end
                  end
                  RSL_CLS_STAT: begin
                     unique case (r.cause)
                        RSL_C_POR: begin
                           next_r.regs[i][`RSL_STAT_TO_BIT] = 1'b0;
                           next_r.regs[i][`RSL_STAT_PDF_BIT] = 1'b0;
                        end
                        RSL_C_PIN: begin
                           if (r.lowpwr) begin
                              next_r.regs[i][`RSL_STAT_TO_BIT] = 1'b0;
                              next_r.regs[i][`RSL_STAT_PDF_BIT] = 1'b1;
                           end
                        end
                        RSL_C_BO: begin
                           next_r.regs[i] = r.regs[i];
                        end
                        RSL_C_WDT: begin
                           next_r.regs[i][`RSL_STAT_TO_BIT] = 1'b1;
                           if (r.lowpwr) begin
                              next_r.regs[i][`RSL_STAT_PDF_BIT] = 1'b1;
                           end
                        end
                     endcase
                  end
                  default: begin
                     next_r.regs[i] = r.regs[i];
                  end
               endcase
            end
            // Set wins over any software clear this cycle
            if (r.cause == RSL_C_BO) begin
               next_r.regs[`RSL_IDX_RSTF][`RSL_RSTF_BO_BIT] = 1'b1;
            end
            next_r.ctl.pc_clear = 1'b1;
            next_r.ctl.sp_clear = wdt_lp;
            next_r.ctl.sp_top = ~wdt_lp;
            next_r.ctl.int_disable = ~wdt_lp;
            next_r.ctl.wdt_tb_clear = ~wdt_lp;
            next_r.ctl.timers_off = ~wdt_lp;
            next_r.ctl.ports_input = ~wdt_lp;
            next_r.cnt = HOLD_LAST;
            next_r.seq = RSL_SQ_HOLD;
         end
         RSL_SQ_HOLD: begin
            // Release waits for every reset level to fall
            if (r.cnt != 4'h0) begin
               next_r.cnt = r.cnt - 4'h1;
            end else if (!any_lvl) begin
               next_r.seq = RSL_SQ_IDLE;
               next_r.core_rst_b = 1'b1;
            end
         end
         default: begin
            next_r.seq = RSL_SQ_IDLE;
         end
      endcase
   end

   // Block reset behaves as a power-on event
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         r <= '0;
         r.seq <= RSL_SQ_APPLY;
         r.cause <= RSL_C_POR;
      end else begin
         r <= next_r;
      end
   end

   assign avs_readdata = {24'h000000, r.rdata};
   assign core_rst_b = r.core_rst_b;
   assign ctl = r.ctl;
   assign view.watchdog_expiry_flag = r.regs[`RSL_IDX_STAT][`RSL_STAT_TO_BIT];
   assign view.powerdown_flag = r.regs[`RSL_IDX_STAT][`RSL_STAT_PDF_BIT];
   assign view.brownout_flag = r.regs[`RSL_IDX_RSTF][`RSL_RSTF_BO_BIT];
   assign view.port_a_data = r.regs[`RSL_IDX_PA];
   assign view.port_a_direction = r.regs[`RSL_IDX_PAC];

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   logic ap;
   logic [7:0] st;
   assign ap = (r.seq == RSL_SQ_APPLY);
   assign st = r.regs[`RSL_IDX_STAT];

   property p_sleep_pdf;
      (r.seq == RSL_SQ_IDLE) && sleep_entry && !flag_clear |=> st[4];
   endproperty
   a_sleep_pdf: assert property (p_sleep_pdf)
      else $error("Powerdown flag not set on sleep entry");

   property p_por_flags;
      ap && r.cause == RSL_C_POR |=> st[5:4] == 2'b00;
   endproperty
   a_por_flags: assert property (p_por_flags)
      else $error("Flags not cleared by power-on reset");

   property p_run_keep;
      ap && !r.lowpwr && (r.cause inside {RSL_C_PIN, RSL_C_BO})
         |=> st[5:4] == $past(st[5:4]);
   endproperty
   a_run_keep: assert property (p_run_keep)
      else $error("Flags changed by running pin or brownout reset");

   property p_wdt_run;
      ap && !r.lowpwr && r.cause == RSL_C_WDT
         |=> st[5] && st[4] == $past(st[4]);
   endproperty
   a_wdt_run: assert property (p_wdt_run)
      else $error("Running watchdog reset flags wrong");

   property p_wdt_lp;
      ap && wdt_lp |=> st[5:4] == 2'b11 && ctl.sp_clear;
   endproperty
   a_wdt_lp: assert property (p_wdt_lp)
      else $error("Low-power watchdog reset flags wrong");

   property p_por_ctl;
      ap && r.cause == RSL_C_POR |=> ctl.pc_clear && ctl.sp_top
         && ctl.int_disable && ctl.wdt_tb_clear && ctl.timers_off
         && ctl.ports_input ##1 ctl == '0;
   endproperty
   a_por_ctl: assert property (p_por_ctl)
      else $error("Power-on control pulses wrong");

   property p_ptr_keep;
      ap && wdt_lp |=> r.regs[`RSL_IDX_MP0] == $past(r.regs[`RSL_IDX_MP0])
         && r.regs[`RSL_IDX_PA] == $past(r.regs[`RSL_IDX_PA]);
   endproperty
   a_ptr_keep: assert property (p_ptr_keep)
      else $error("Pointer or port changed by low-power watchdog");

   property p_zero_ones;
      ap && !wdt_lp |=> r.regs[`RSL_IDX_MP0] == 8'h00
         && r.regs[`RSL_IDX_INTERRUPT_CONTROL_0] == 8'h00 && view.port_a_data == 8'hff;
   endproperty
   a_zero_ones: assert property (p_zero_ones)
      else $error("Reset values not loaded");

   property p_acc_keep;
      ap && r.cause != RSL_C_POR
         |=> r.regs[`RSL_IDX_ACC] == $past(r.regs[`RSL_IDX_ACC]);
   endproperty
   a_acc_keep: assert property (p_acc_keep)
      else $error("Accumulator changed by non power-on reset");

   property p_pcl;
      ap |=> r.regs[`RSL_IDX_PCL] == 8'h00;
   endproperty
   a_pcl: assert property (p_pcl)
      else $error("Program counter low not cleared");

   property p_bo_flag;
      ap && r.cause == RSL_C_BO |=> view.brownout_flag;
   endproperty
   a_bo_flag: assert property (p_bo_flag)
      else $error("Brownout flag not set");

   property p_hold;
      ap |-> !core_rst_b [*5];
   endproperty
   a_hold: assert property (p_hold)
      else $error("Core released before hold time");

   c_por: cover property (ap && r.cause == RSL_C_POR ##1 1'b1);
   c_wdt_lp: cover property (ap && wdt_lp);
   c_pin_lp: cover property (ap && r.cause == RSL_C_PIN && r.lowpwr);
   c_bus_rd: cover property (avs_read && !avs_waitrequest);
endmodule : rsl_core

// ---- verif/rsl_core_test.sv ----
`timescale 1ns/1ps
`include "rsl_defs.svh"

module rsl_core_test;
   import rsl_pkg::*;
   logic sys_clk, rst_b, wdt_expiry, sleep_entry, flag_clear;
   logic avs_read, avs_write, avs_waitrequest, core_rst_b;
   rsl_req_t rst_req;
   rsl_mode_t mode;
   logic [6:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   rsl_ctl_t ctl;
   rsl_view_t view;
   int n_fail = 0;
   int comparisons = 0;
   logic to_f, pd_f;
   logic [7:0] base;

   rsl_core dut (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .rst_req(rst_req),
      .wdt_expiry(wdt_expiry),
      .mode(mode),
      .sleep_entry(sleep_entry),
      .flag_clear(flag_clear),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .core_rst_b(core_rst_b),
      .ctl(ctl),
      .view(view)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("counts: %0d compared, %0d failed", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   function automatic logic [7:0] msk(input int i);
      case (i)
         `RSL_IDX_TABLE_HIGH_POINTER: msk = `RSL_MASK_TABLE_HIGH_POINTER;
         `RSL_IDX_PBP: msk = `RSL_MASK_PBP;
         `RSL_IDX_INTERRUPT_CONTROL_0: msk = `RSL_MASK_INTERRUPT_CONTROL_0;
         `RSL_IDX_RSTF: msk = `RSL_MASK_RSTF;
         default: msk = 8'hff;
      endcase
   endfunction : msk

   function automatic logic [7:0] pat(input int i);
      pat = (base ^ (8'(i) * 8'h1d)) & msk(i);
   endfunction : pat

   // Expected contents after reset c; lp means taken in idle or sleep
   function automatic logic [7:0] exp_reg(input int i, input rsl_cause_t c,
                                          input logic lp);
      logic keep;
      logic por;
      keep = (c == RSL_C_WDT) && lp;
      por = (c == RSL_C_POR);
      case (i)
         5, 7, 8, 9: exp_reg = por ? 8'h00 : pat(i);
         6: exp_reg = 8'h00;
         10: exp_reg = por ? 8'h00 : (pat(i) & 8'hcf) |
                       {2'b00, to_f, pd_f, 4'h0};
         15: exp_reg = por ? 8'h00 :
                       pat(i) | (c == RSL_C_BO ? 8'h04 : 8'h00);
         20, 21: exp_reg = keep ? pat(i) : 8'hff;
         default: exp_reg = keep ? pat(i) : 8'h00;
      endcase
   endfunction : exp_reg

   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [6:0] a,
                      input logic [7:0] d, output logic [31:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      chk("bus answer", {31'h0, n < 100}, 32'h1);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : bus

   task automatic fill;
      for (int i = 0; i < `RSL_NREG; i++) begin
         bus(1'b1, 7'(i * 4), pat(i), q);
      end
   endtask : fill

   task automatic check_regs(input rsl_cause_t c, input logic lp);
      logic [31:0] m;
      for (int i = 0; i < `RSL_NREG; i++) begin
         // Power-on leaves the other status bits undefined
         m = (i == 10 && c == RSL_C_POR) ? 32'h30 : 32'hff;
         bus(1'b0, 7'(i * 4), 8'h00, q);
         chk($sformatf("reg %0d", i), q & 32'hffffff00, 32'h0);
         chk($sformatf("reg %0d", i), q & m, exp_reg(i, c, lp) & m);
      end
      chk("expiry flag", view.watchdog_expiry_flag, to_f);
      chk("powerdown flag", view.powerdown_flag, pd_f);
      chk("brownout flag", view.brownout_flag, exp_reg(15, c, lp) >> 2
          & 1);
      chk("port a", view.port_a_data, exp_reg(20, c, lp));
      chk("port a dir", view.port_a_direction, exp_reg(21, c, lp));
   endtask : check_regs

   task automatic pulse(input logic sl);
      if (sl) begin
         sleep_entry <= 1'b1;
         to_f = 1'b0;
         pd_f = 1'b1;
      end else begin
         flag_clear <= 1'b1;
         to_f = 1'b0;
         pd_f = 1'b0;
      end
      @(posedge sys_clk);
      sleep_entry <= 1'b0;
      flag_clear <= 1'b0;
      @(posedge sys_clk);
   endtask : pulse

   task automatic do_rst(input rsl_cause_t c, input rsl_mode_t md);
      rsl_ctl_t seen;
      int low;
      int n;
      logic lp;
      lp = md[1];
      seen = '0;
      low = 0;
      n = 0;
      mode <= md;
      @(posedge sys_clk);
      case (c)
         RSL_C_POR: rst_req.por <= 1'b1;
         RSL_C_PIN: rst_req.pin <= 1'b1;
         RSL_C_BO: rst_req.brownout <= 1'b1;
         default: wdt_expiry <= 1'b1;
      endcase
      do begin
         @(posedge sys_clk);
         n++;
         wdt_expiry <= 1'b0;
         if (n == 3) begin
            rst_req <= '0;
         end
         seen = seen | ctl;
         if (core_rst_b === 1'b0) begin
            low++;
         end
      end while (!(low > 0 && core_rst_b === 1'b1) && n < 60);
      chk("ctl", seen, (c == RSL_C_WDT && lp) ? 7'h50 : 7'h6f);
      chk("hold", {31'h0, low >= 5}, 32'h1);
      case (c)
         RSL_C_POR: {to_f, pd_f} = 2'b00;
         RSL_C_PIN: if (lp) {to_f, pd_f} = 2'b01;
         RSL_C_WDT: {to_f, pd_f} = {1'b1, pd_f | lp};
         default: ;
      endcase
      mode <= RSL_FAST;
      check_regs(c, lp);
   endtask : do_rst

   task automatic t_pin_run;
      base = 8'ha5;
      fill();
      pulse(1'b1);
      do_rst(RSL_C_PIN, RSL_FAST);
      $display("test pin_run done");
   endtask : t_pin_run

   task automatic t_wdt_run;
      base = 8'h3c;
      fill();
      pulse(1'b0);
      do_rst(RSL_C_WDT, RSL_SLOW);
      $display("test wdt_run done");
   endtask : t_wdt_run

   task automatic t_wdt_low;
      base = 8'h96;
      fill();
      do_rst(RSL_C_WDT, RSL_IDLE);
      base = 8'h69;
      fill();
      pulse(1'b0);
      do_rst(RSL_C_WDT, RSL_SLEEP);
      $display("test wdt_low done");
   endtask : t_wdt_low

   task automatic t_pin_low;
      base = 8'h0f;
      fill();
      do_rst(RSL_C_PIN, RSL_SLEEP);
      $display("test pin_low done");
   endtask : t_pin_low

   task automatic t_brownout;
      base = 8'hc3;
      fill();
      do_rst(RSL_C_BO, RSL_SLOW);
      bus(1'b1, 7'h3c, 8'h00, q);
      bus(1'b0, 7'h3c, 8'h00, q);
      chk("flag reg", q, 32'h0);
      chk("brownout flag", view.brownout_flag, 1'b0);
      $display("test brownout done");
   endtask : t_brownout

   task automatic t_por_req;
      base = 8'h5a;
      fill();
      pulse(1'b1);
      do_rst(RSL_C_POR, RSL_IDLE);
      $display("test por_req done");
   endtask : t_por_req

   task automatic t_bus;
      bus(1'b1, 7'h58, 8'h77, q);
      bus(1'b0, 7'h58, 8'h00, q);
      chk("unmapped", q, 32'h0);
      bus(1'b0, 7'h05, 8'h00, q);
      chk("misaligned", q, 32'h0);
      bus(1'b1, 7'h28, 8'hff, q);
      bus(1'b0, 7'h28, 8'h00, q);
      chk("status", q, {24'h0, 2'b11, to_f, pd_f, 4'hf});
      $display("test bus done");
   endtask : t_bus

   initial begin
      rst_b = 1'b0;
      rst_req = '0;
      wdt_expiry = 1'b0;
      mode = RSL_FAST;
      sleep_entry = 1'b0;
      flag_clear = 1'b0;
      avs_address = 7'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      to_f = 1'b0;
      pd_f = 1'b0;
      base = 8'h00;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      check_regs(RSL_C_POR, 1'b0);
      $display("test por_initial done");
      t_pin_run();
      t_wdt_run();
      t_wdt_low();
      t_pin_low();
      t_brownout();
      t_por_req();
      t_bus();
      tally_and_finish();
   end

   // Whole run needs about eleven hundred cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      $display("watchdog ran out");
      tally_and_finish();
   end

endmodule : rsl_core_test
